// [core/afst_pkg.sv]
// Shared constants and types of the asynchronous flash access sequencer
package afst_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int TW      = 5;
  localparam int UNIT_W  = 8;
  localparam int CYC_W   = 10;
  localparam int DATA_W  = 16;
  localparam int NUM_CS  = 8;
  localparam int WAIT_N  = 2;

  // ----------------------------------------------------------------
  // Page sizes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]        PAGE_WORDS   = 3'h4;
  localparam logic [2:0]        W32_WORDS    = 3'h2;
  localparam logic [2:0]        SINGLE_WORDS = 3'h1;
  localparam logic [NUM_CS-1:0] CS_IDLE      = 8'hff;
  localparam logic [1:0]        WAIT_IDLE    = 2'h3;
  localparam logic [DATA_W-1:0] DATA_RST     = 16'h0000;

  // Core clock period, for reference by timing users
  localparam int CLK_PERIOD_NS = 40;

  // ----------------------------------------------------------------
  // Access kinds and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    K_NOR_READ,
    K_NOR_READ32,
    K_NOR_PAGE,
    K_NOR_WRITE,
    K_NAND_CMD,
    K_NAND_ADDR,
    K_NAND_READ,
    K_NAND_WRITE
  } afst_kind_type;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } afst_state_type;

endpackage : afst_pkg

// [core/afst_seq.sv]
// Cycle timing engine for asynchronous NOR and NAND flash accesses
`timescale 1ns/1ps
// Contract
// - Single read samples data read_sample_cycles scaled units after access start.
// - Page read captures its first word after read_sample_cycles from start.
// - Each later page word is captured page_word_cycles after the previous word.
// - Each later page address phase starts at the capture of the previous word.
// - The timing clock stays internal and never leaves the block on a pin.
// - An internal bus direction flag is produced and kept off the pads.
// - Eight active low selects; the chosen one goes low before read strobe.
// - NAND read samples after read_sample_cycles times one plus scale bit.
// - NAND write strobe is active for strobe end minus start, scaled.
// - Write strobe follows select by start difference scaled plus half shifts.
// - NAND command latch on byte pins, address latch on valid pin, before strobe.
// - NAND write data is driven from access start, ahead of write strobe.
// - NAND write cycle lasts write_cycle_len times one plus scale bit.
// - Write data stays driven after write strobe until write cycle end.
// - Select releases after write strobe per select and strobe end times.
// - Command or address latch releases after write strobe per latch end time.
// - NAND read strobe is active for strobe end minus start, scaled.
// - NAND read cycle lasts read_cycle_len times one plus scale bit.
// - Select releases after read strobe per read select and strobe ends.
// - With all half shift bits clear, no edge moves by half a cycle.
module afst_seq
  import afst_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Timing configuration
  input  wire logic              timing_scale_bit,
  input  wire logic [TW-1:0]     select_start,
  input  wire logic [TW-1:0]     select_end_read,
  input  wire logic [TW-1:0]     select_end_write,
  input  wire logic [TW-1:0]     latch_start,
  input  wire logic [TW-1:0]     latch_end_write,
  input  wire logic [TW-1:0]     rd_strobe_start,
  input  wire logic [TW-1:0]     rd_strobe_end,
  input  wire logic [TW-1:0]     wr_strobe_start,
  input  wire logic [TW-1:0]     wr_strobe_end,
  input  wire logic [TW-1:0]     read_cycle_len,
  input  wire logic [TW-1:0]     write_cycle_len,
  input  wire logic [TW-1:0]     read_sample_cycles,
  input  wire logic [TW-1:0]     page_word_cycles,
  input  wire logic              select_half_shift,
  input  wire logic              latch_half_shift,
  input  wire logic              wr_strobe_half_shift,
  input  wire logic              rd_strobe_half_shift,
  input  wire logic              addr_mux_mode,
  input  wire logic              wait_enable,
  input  wire logic              wait_select,
  // Access request
  input  wire logic              req_valid,
  output      logic              req_ready,
  input  wire afst_kind_type     req_kind,
  input  wire logic [2:0]        req_cs,
  input  wire logic [DATA_W-1:0] req_addr,
  input  wire logic [1:0]        req_be_n,
  input  wire logic [DATA_W-1:0] req_wdata,
  // Access answer
  output      logic [DATA_W-1:0] rdata_word,
  output      logic [1:0]        rdata_index,
  output      logic              rdata_valid,
  output      logic              acc_done,
  output      logic              bus_dir,
  // Flash pins
  output      logic [NUM_CS-1:0] flash_cs_n,
  output      logic              flash_adv_ale,
  output      logic              flash_oe_n,
  output      logic              flash_we_n,
  output      logic [1:0]        flash_be_cle,
  output      logic [DATA_W-1:0] flash_addr,
  output      logic [DATA_W-1:0] flash_ad_out,
  output      logic              flash_ad_oe,
  input  wire logic [DATA_W-1:0] flash_ad_in,
  input  wire logic [WAIT_N-1:0] flash_wait
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [UNIT_W-1:0] mul_units(input logic [2:0] n,
                                                   input logic [TW-1:0] p);
    mul_units = {5'h00, n} * {3'h0, p};
  endfunction : mul_units

  function automatic logic [UNIT_W-1:0] widen(input logic [TW-1:0] t);
    widen = {3'h0, t};
  endfunction : widen

  function automatic logic in_win(input logic [UNIT_W-1:0] u,
                                  input logic [UNIT_W-1:0] s,
                                  input logic [UNIT_W-1:0] e);
    in_win = (u >= s) && (u < e);
  endfunction : in_win

  // ----------------------------------------------------------------
  // Wait synchroniser
  // ----------------------------------------------------------------
  afst_wait_if wif ();

  afst_wait_sync u_wait (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wait_pin (flash_wait),
    .wif      (wif)
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  afst_state_type    state_q;
  afst_kind_type     kind_q;
  logic [2:0]        cs_q;
  logic [DATA_W-1:0] addr_q;
  logic [1:0]        be_q;
  logic [DATA_W-1:0] wdata_q;
  logic              pre_q;
  logic [UNIT_W-1:0] unit_q;
  logic [1:0]        word_q;
  logic [CYC_W-1:0]  cyc_q;
  logic              done_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        ridx_q;
  logic              rvalid_q;

  logic              run;
  logic              start;
  logic              is_read;
  logic              is_nor;
  logic              is_page;
  logic              is_nand_rw;
  logic [2:0]        nwords;
  logic [UNIT_W-1:0] ext;
  logic [UNIT_W-1:0] cyc_len;
  logic [UNIT_W-1:0] cs_end;
  logic [UNIT_W-1:0] oe_end;
  logic [UNIT_W-1:0] sample_at;
  logic              boundary;
  logic              unit_last;
  logic              last_cyc;
  logic              hold_point;
  logic              ready_sel;
  logic              stall;
  logic              sample_hit;
  logic              word_step;
  logic [1:0]        word_d;

  assign run        = (state_q == ST_RUN);
  assign start      = req_valid && !run;
  assign req_ready  = !run;
  assign is_read    = (kind_q == K_NOR_READ) || (kind_q == K_NOR_READ32) ||
                      (kind_q == K_NOR_PAGE) || (kind_q == K_NAND_READ);
  assign is_nor     = (kind_q == K_NOR_READ) || (kind_q == K_NOR_READ32) ||
                      (kind_q == K_NOR_PAGE) || (kind_q == K_NOR_WRITE);
  assign is_page    = (kind_q == K_NOR_READ32) || (kind_q == K_NOR_PAGE);
  assign is_nand_rw = (kind_q == K_NAND_READ) || (kind_q == K_NAND_WRITE);
  assign nwords     = (kind_q == K_NOR_PAGE)   ? PAGE_WORDS :
                      (kind_q == K_NOR_READ32) ? W32_WORDS  : SINGLE_WORDS;

  // Later page words stretch the read window by one page slot each
  assign ext       = mul_units(nwords - 3'h1, page_word_cycles);
  assign cyc_len   = is_read ? widen(read_cycle_len) + ext : widen(write_cycle_len);
  assign cs_end    = is_read ? widen(select_end_read) + ext : widen(select_end_write);
  assign oe_end    = widen(rd_strobe_end) + ext;
  assign sample_at = widen(read_sample_cycles) + mul_units({1'b0, word_q}, page_word_cycles);

  // A unit is one or two core cycles; edges fall on unit boundaries
  assign boundary  = !pre_q;
  assign unit_last = (pre_q == timing_scale_bit);
  assign last_cyc  = unit_last && (unit_q == cyc_len - 8'h01);

  // Stretch at the sample point of a read or the strobe end of a write
  assign ready_sel  = wif.ready_lvl[wait_select];
  assign hold_point = boundary && (unit_q == (is_read ? sample_at : widen(wr_strobe_end)));
  assign stall      = run && wait_enable && !ready_sel && hold_point;
  assign sample_hit = run && is_read && boundary &&
                      (unit_q == sample_at) && !stall;
  // Next word is known at the capture edge, so its address phase starts there
  assign word_step  = sample_hit && ({1'b0, word_q} < nwords - 3'h1);
  assign word_d     = word_step ? word_q + 2'h1 : word_q;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      kind_q  <= K_NOR_READ;
      cs_q    <= 3'h0;
      addr_q  <= DATA_RST;
      be_q    <= 2'h3;
      wdata_q <= DATA_RST;
      pre_q   <= 1'b0;
      unit_q  <= 8'h00;
      word_q  <= 2'h0;
      cyc_q   <= 10'h000;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            state_q <= ST_RUN;
            kind_q  <= req_kind;
            cs_q    <= req_cs;
            addr_q  <= req_addr;
            be_q    <= req_be_n;
            wdata_q <= req_wdata;
            pre_q   <= 1'b0;
            unit_q  <= 8'h00;
            word_q  <= 2'h0;
            cyc_q   <= 10'h000;
          end
        end
        ST_RUN:
        begin
          if (!stall)
          begin
            cyc_q <= cyc_q + 10'h001;
            if (last_cyc)
            begin
              state_q <= ST_IDLE;
              done_q  <= 1'b1;
            end
            else if (unit_last)
            begin
              pre_q  <= 1'b0;
              unit_q <= unit_q + 8'h01;
            end
            else
            begin
              pre_q <= 1'b1;
            end
            word_q <= word_d;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  // Pin data is taken raw: the strobe timing itself provides the setup
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q  <= DATA_RST;
      ridx_q   <= 2'h0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= sample_hit;
      if (sample_hit)
      begin
        rdata_q <= flash_ad_in;
        ridx_q  <= word_q;
      end
    end
  end

  assign rdata_word  = rdata_q;
  assign rdata_index = ridx_q;
  assign rdata_valid = rvalid_q;
  assign acc_done    = done_q;

  // ----------------------------------------------------------------
  // Strobe windows
  // ----------------------------------------------------------------
  logic cs_lv_d;
  logic oe_lv_d;
  logic we_lv_d;
  logic lat_lv_d;
  logic drive_d;
  logic mux_addr;
  logic cs_lv_q;
  logic oe_lv_q;
  logic we_lv_q;
  logic lat_lv_q;
  logic cs_lv_n_q;
  logic oe_lv_n_q;
  logic we_lv_n_q;
  logic lat_lv_n_q;
  logic cs_act;
  logic oe_act;
  logic we_act;
  logic lat_act;
  logic [DATA_W-1:0] addr_out_q;
  logic [DATA_W-1:0] ad_out_q;
  logic              ad_oe_q;

  assign cs_lv_d  = run && in_win(unit_q, widen(select_start), cs_end);
  assign oe_lv_d  = run && is_read &&
                    in_win(unit_q, widen(rd_strobe_start), oe_end);
  assign we_lv_d  = run && !is_read &&
                    in_win(unit_q, widen(wr_strobe_start), widen(wr_strobe_end));
  assign lat_lv_d = run && (is_nor || (kind_q == K_NAND_CMD) || (kind_q == K_NAND_ADDR)) &&
                    in_win(unit_q, widen(latch_start), widen(latch_end_write));
  assign mux_addr = addr_mux_mode && is_nor && (unit_q < widen(latch_end_write));
  assign drive_d  = run && (!is_read || mux_addr);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_lv_q    <= 1'b0;
      oe_lv_q    <= 1'b0;
      we_lv_q    <= 1'b0;
      lat_lv_q   <= 1'b0;
      addr_out_q <= DATA_RST;
      ad_out_q   <= DATA_RST;
      ad_oe_q    <= 1'b0;
    end
    else
    begin
      cs_lv_q    <= cs_lv_d;
      oe_lv_q    <= oe_lv_d;
      we_lv_q    <= we_lv_d;
      lat_lv_q   <= lat_lv_d;
      addr_out_q <= addr_q + {14'h0000, word_d};
      ad_out_q   <= mux_addr ? addr_q : wdata_q;
      ad_oe_q    <= drive_d;
    end
  end

  // Falling-edge copies give the half-cycle shift on one clock
  always_ff @(negedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_lv_n_q  <= 1'b0;
      oe_lv_n_q  <= 1'b0;
      we_lv_n_q  <= 1'b0;
      lat_lv_n_q <= 1'b0;
    end
    else
    begin
      cs_lv_n_q  <= cs_lv_q;
      oe_lv_n_q  <= oe_lv_q;
      we_lv_n_q  <= we_lv_q;
      lat_lv_n_q <= lat_lv_q;
    end
  end

  // Clear shift bits select the rising-edge flops untouched
  assign cs_act  = select_half_shift    ? cs_lv_n_q  : cs_lv_q;
  assign oe_act  = rd_strobe_half_shift ? oe_lv_n_q  : oe_lv_q;
  assign we_act  = wr_strobe_half_shift ? we_lv_n_q  : we_lv_q;
  assign lat_act = latch_half_shift     ? lat_lv_n_q : lat_lv_q;

  // ----------------------------------------------------------------
  // Pin mapping
  // ----------------------------------------------------------------
  // No pin carries the core clock; only timed levels leave the block
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CS; gi++)
    begin : g_cs
      assign flash_cs_n[gi] = !(cs_act && (cs_q == 3'(gi)));
    end
  endgenerate

  assign flash_oe_n    = !oe_act;
  assign flash_we_n    = !we_act;
  // NOR address valid is low active; NAND address latch is high active
  assign flash_adv_ale = is_nor ? !lat_act : (lat_act && (kind_q == K_NAND_ADDR));
  assign flash_be_cle  = (kind_q == K_NAND_CMD) ? {2{lat_act}} :
                         is_nand_rw             ? 2'h0 :
                         (is_nor && run)        ? be_q : 2'h3;
  assign flash_addr    = addr_out_q;
  assign flash_ad_out  = ad_out_q;
  assign flash_ad_oe   = ad_oe_q;
  assign bus_dir       = ad_oe_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CYC_W-1:0] scale_n;
  logic [CYC_W-1:0] gap_q;
  logic [CYC_W-1:0] we_cnt_q;
  logic [CYC_W-1:0] oe_cnt_q;
  logic             stall_q;

  assign scale_n = {9'h000, timing_scale_bit} + 10'h001;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gap_q    <= 10'h000;
      we_cnt_q <= 10'h000;
      oe_cnt_q <= 10'h000;
      stall_q  <= 1'b0;
    end
    else
    begin
      gap_q    <= sample_hit ? 10'h001 : gap_q + 10'h001;
      we_cnt_q <= we_lv_q ? we_cnt_q + 10'h001 : 10'h000;
      // A stalled cycle repeats its unit, so it adds no strobe width
      oe_cnt_q <= oe_lv_q ? oe_cnt_q + {9'h000, !stall_q} : 10'h000;
      stall_q  <= stall;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_single_sample: assert property (sample_hit && !wait_enable && !is_page &&
    kind_q != K_NAND_READ |-> cyc_q == {5'h00, read_sample_cycles} * scale_n)
    else $error("single read sampled at wrong cycle");
  a_page_first: assert property (sample_hit && !wait_enable && is_page && word_q == 2'h0
    |-> cyc_q == {5'h00, read_sample_cycles} * scale_n)
    else $error("first page word sampled at wrong cycle");
  a_page_next: assert property (sample_hit && !wait_enable && word_q != 2'h0
    |-> gap_q == {5'h00, page_word_cycles} * scale_n)
    else $error("page word spacing wrong");
  a_page_addr: assert property (run && is_page && (addr_out_q != $past(addr_out_q))
    |-> $past(sample_hit) || $past(start, 2))
    else $error("page address moved without a capture");
  a_nand_sample: assert property (sample_hit && !wait_enable && kind_q == K_NAND_READ
    |-> cyc_q == {5'h00, read_sample_cycles} * scale_n)
    else $error("nand read sampled at wrong cycle");
  a_we_width: assert property ($fell(we_lv_q) && !wait_enable |->
    we_cnt_q == ({5'h00, wr_strobe_end} - {5'h00, wr_strobe_start}) * scale_n)
    else $error("write strobe width wrong");
  a_oe_width: assert property ($fell(oe_lv_q) && !is_page |->
    oe_cnt_q == ({5'h00, rd_strobe_end} - {5'h00, rd_strobe_start}) * scale_n)
    else $error("read strobe width wrong");
  a_wr_cycle: assert property (done_q && !wait_enable && !$past(is_read) |->
    $past(cyc_q) + 10'h001 == {5'h00, write_cycle_len} * scale_n)
    else $error("write cycle length wrong");
  a_rd_cycle: assert property (done_q && !wait_enable && $past(kind_q) == K_NAND_READ |->
    $past(cyc_q) + 10'h001 == {5'h00, read_cycle_len} * scale_n)
    else $error("read cycle length wrong");
  a_cs_before_oe: assert property ($rose(oe_lv_q) |-> cs_lv_q)
    else $error("read strobe active without select");

endmodule : afst_seq

// [core/afst_wait_if.sv]
// Carrier of the filtered wait levels between the synchroniser and the sequencer
`timescale 1ns/1ps
interface afst_wait_if;
  logic [1:0] ready_lvl;
  modport drive (output ready_lvl);
  modport sink  (input  ready_lvl);
endinterface : afst_wait_if

// [core/afst_wait_sync.sv]
// Three-stage synchroniser and agreement filter for the flash wait pins
`timescale 1ns/1ps
module afst_wait_sync
  import afst_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Raw wait pins
  input  wire logic [WAIT_N-1:0] wait_pin,
  // Filtered levels
  afst_wait_if.drive             wif
);

  logic [WAIT_N-1:0] s1_q;
  logic [WAIT_N-1:0] s2_q;
  logic [WAIT_N-1:0] s3_q;
  logic [WAIT_N-1:0] lvl_q;
  logic [WAIT_N-1:0] agree;
  logic [WAIT_N-1:0] lvl_d;

  // A level only counts once two later stages agree
  assign agree = ~(s2_q ^ s3_q);
  assign lvl_d = (agree & s3_q) | (~agree & lvl_q);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q  <= WAIT_IDLE;
      s2_q  <= WAIT_IDLE;
      s3_q  <= WAIT_IDLE;
      lvl_q <= WAIT_IDLE;
    end
    else
    begin
      s1_q  <= wait_pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign wif.ready_lvl = lvl_q;

  a_filter_agree: assert property (@(posedge core_clk) disable iff (!nrst)
    (lvl_q != $past(lvl_q)) |-> ($past(s2_q) == $past(s3_q)))
    else $error("wait level changed without stage agreement");

endmodule : afst_wait_sync

// [sim/afst_flash_model.sv]
// Behavioural flash device answering reads and driving the wait pins
`timescale 1ns/1ps
module afst_flash_model
  import afst_pkg::*;
(
  // Clock
  input  wire logic              core_clk,
  // Flash pins
  input  wire logic [NUM_CS-1:0] flash_cs_n,
  input  wire logic              flash_oe_n,
  input  wire logic [DATA_W-1:0] flash_addr,
  output      logic [DATA_W-1:0] flash_ad_in,
  output      logic [WAIT_N-1:0] flash_wait,
  // Test control
  input  wire logic              hold,
  input  wire logic              wsel
);
  logic              drv;
  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] last_q = 16'h5a5a;
  assign drv  = !flash_oe_n && (flash_cs_n != CS_IDLE);
  assign word = flash_addr ^ 16'ha5c3;
  // Released bus shows the inverse, so a late capture never matches
  assign flash_ad_in = drv ? word : ~last_q;
  // Only the chosen wait pin reports not ready
  assign flash_wait  = !hold ? WAIT_IDLE : (wsel ? 2'h1 : 2'h2);
  always @(posedge core_clk)
    if (drv)
      last_q <= word;
endmodule : afst_flash_model

// [sim/async_nor_nand_access_timing_tb_top.sv]
// Self-checking bench for the asynchronous flash access sequencer
`timescale 1ns/1ps
module async_nor_nand_access_timing_tb_top
  import afst_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst     = 1'b0;
  logic timing_scale_bit, select_half_shift, latch_half_shift, wr_strobe_half_shift;
  logic rd_strobe_half_shift, addr_mux_mode, wait_enable, wait_select, req_valid, hold;
  logic [TW-1:0] select_start, select_end_read, select_end_write, latch_start, latch_end_write;
  logic [TW-1:0] rd_strobe_start, rd_strobe_end, wr_strobe_start, wr_strobe_end;
  logic [TW-1:0] read_cycle_len, write_cycle_len, read_sample_cycles, page_word_cycles;
  afst_kind_type     req_kind;
  logic [2:0]        req_cs;
  logic [1:0]        req_be_n, rdata_index, flash_be_cle;
  logic [WAIT_N-1:0] flash_wait;
  logic [DATA_W-1:0] req_addr, req_wdata, rdata_word, flash_addr, flash_ad_out, flash_ad_in;
  logic [NUM_CS-1:0] flash_cs_n;
  logic req_ready, rdata_valid, acc_done, bus_dir, flash_adv_ale, flash_oe_n, flash_we_n;
  logic flash_ad_oe, busy, lat;
  int   bad_count, checks_done, cyc, hc, f_cs, f_oe, f_we, f_la, n_cs, n_oe, n_we, n_la, n_x, nw;
  always #20 core_clk = ~core_clk;
  afst_seq dut_u (.core_clk, .nrst, .timing_scale_bit, .select_start, .select_end_read,
    .select_end_write, .latch_start, .latch_end_write, .rd_strobe_start, .rd_strobe_end,
    .wr_strobe_start, .wr_strobe_end, .read_cycle_len, .write_cycle_len, .read_sample_cycles,
    .page_word_cycles, .select_half_shift, .latch_half_shift, .wr_strobe_half_shift,
    .rd_strobe_half_shift, .addr_mux_mode, .wait_enable, .wait_select, .req_valid, .req_ready,
    .req_kind, .req_cs, .req_addr, .req_be_n, .req_wdata, .rdata_word, .rdata_index, .rdata_valid,
    .acc_done, .bus_dir, .flash_cs_n, .flash_adv_ale, .flash_oe_n, .flash_we_n, .flash_be_cle,
    .flash_addr, .flash_ad_out, .flash_ad_oe, .flash_ad_in, .flash_wait);
  afst_flash_model flash_u (.core_clk, .flash_cs_n, .flash_oe_n, .flash_addr, .flash_ad_in,
    .flash_wait, .hold, .wsel(wait_select));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------
  // Pin monitor, sampled just after both clock edges
  // ----------------------------------------------------------------
  assign lat = (req_kind == K_NAND_CMD) ? (flash_be_cle == 2'h3) : flash_adv_ale;
  always @(core_clk)
  begin
    #1;
    if (busy)
    begin
      hc++;
      if (!flash_cs_n[req_cs] && f_cs < 0) f_cs = hc;
      if (!flash_oe_n && f_oe < 0) f_oe = hc;
      if (!flash_we_n && f_we < 0) f_we = hc;
      if (lat && f_la < 0) f_la = hc;
      n_cs += !flash_cs_n[req_cs];
      n_oe += !flash_oe_n;
      n_we += !flash_we_n;
      n_la += lat;
      n_x  += (flash_cs_n | (8'h01 << req_cs)) != CS_IDLE;
      // Written word must stand on a driven bus for the whole strobe
      if (!flash_we_n)
        n_x += !(flash_ad_oe === 1'b1 && flash_ad_out === req_wdata && bus_dir === 1'b1);
      if (!flash_oe_n)
        n_x += !(flash_ad_oe === 1'b0 && bus_dir === 1'b0);
      if (core_clk && rdata_valid === 1'b1)
      begin
        chk({rdata_index, rdata_word}, {nw[1:0], (req_addr + 16'(nw)) ^ 16'ha5c3});
        nw++;
      end
    end
  end
  // ----------------------------------------------------------------
  // Random timing set, ordered so that every window is legal
  // ----------------------------------------------------------------
  task automatic cfg;
    {timing_scale_bit, select_half_shift, latch_half_shift} = 3'($urandom);
    {wr_strobe_half_shift, rd_strobe_half_shift, wait_select} = 3'($urandom);
    select_start = TW'($urandom % 2);
    latch_start = select_start;
    wr_strobe_start = select_start + TW'(1 + $urandom % 2);
    rd_strobe_start = wr_strobe_start;
    read_sample_cycles = rd_strobe_start + TW'(1 + $urandom % 2);
    rd_strobe_end = read_sample_cycles + 5'h01;
    wr_strobe_end = wr_strobe_start + TW'(1 + $urandom % 2);
    latch_end_write = wr_strobe_end + TW'(1 + $urandom % 2);
    select_end_read = rd_strobe_end + TW'($urandom % 2);
    select_end_write = latch_end_write + TW'($urandom % 2);
    read_cycle_len = select_end_read + 5'h01;
    write_cycle_len = select_end_write + 5'h01;
    page_word_cycles = TW'(1 + $urandom % 3);
    {req_cs, req_be_n} = 5'($urandom);
    req_addr = 16'($urandom);
    req_wdata = 16'($urandom);
  endtask : cfg
  task automatic run(input afst_kind_type k, input bit stall);
    int n, w, u, l, e;
    bit rd;
    @(negedge core_clk);
    cfg();
    rd = k inside {K_NOR_READ, K_NOR_READ32, K_NOR_PAGE, K_NAND_READ};
    addr_mux_mode = (k < K_NAND_CMD) && $urandom % 2;
    // Multiplexed address phase must end before either strobe starts
    if (addr_mux_mode)
      latch_end_write = wr_strobe_start;
    if (stall)
      timing_scale_bit = 1'b1;
    u = timing_scale_bit + 1;
    w = (k == K_NOR_PAGE) ? 4 : (k == K_NOR_READ32) ? 2 : 1;
    {f_cs, f_oe, f_we, f_la} = {4{-32'sd1}};
    {hc, n_cs, n_oe, n_we, n_la, n_x, nw, n} = '0;
    req_kind = k;
    hold = stall;
    wait_enable = stall;
    req_valid = 1'b1;
    @(posedge core_clk);
    busy = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    chk(req_ready, 1'b0);
    while (n < 200 && acc_done !== 1'b1)
    begin
      @(negedge core_clk);
      n++;
      if (n == 20)
        hold <= 1'b0;
    end
    busy = 1'b0;
    l = (rd ? read_cycle_len + (w - 1) * page_word_cycles : write_cycle_len) * u;
    if (stall)
      chk(n > l, 1);
    else
      chk(n, l);
    if (rd)
      chk(nw, w);
    if (!stall)
    begin
      e = rd ? select_end_read - select_start + (w - 1) * page_word_cycles
             : select_end_write - select_start;
      chk(n_cs, 2 * e * u);
      chk(n_x, 0);
      if (rd)
      begin
        chk(f_oe - f_cs, 2 * (rd_strobe_start - select_start) * u
            + rd_strobe_half_shift - select_half_shift);
        chk(n_oe, 2 * (rd_strobe_end - rd_strobe_start + (w - 1) * page_word_cycles) * u);
      end
      else
      begin
        chk(f_we - f_cs, 2 * (wr_strobe_start - select_start) * u
            + wr_strobe_half_shift - select_half_shift);
        chk(n_we, 2 * (wr_strobe_end - wr_strobe_start) * u);
      end
      if (k inside {K_NAND_CMD, K_NAND_ADDR})
      begin
        chk(f_we - f_la, 2 * (wr_strobe_start - latch_start) * u
            + wr_strobe_half_shift - latch_half_shift);
        chk(n_la, 2 * (latch_end_write - latch_start) * u);
      end
    end
    $display("test kind %0d stall %0d ended after %0d cycles", k, stall, n);
  endtask : run
  always @(posedge core_clk)
    if (++cyc == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  initial
  begin
    cyc = $urandom(32'hbd9d);
    {cyc, busy, hold, req_valid, addr_mux_mode, wait_enable} = {32'h0, 5'h00};
    req_kind = K_NOR_READ;
    cfg();
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    for (int i = 0; i < 48; i++)
      run(afst_kind_type'(i % 8), 1'b0);
    run(K_NOR_READ, 1'b1);
    run(K_NAND_READ, 1'b1);
    end_of_test();
  end
endmodule : async_nor_nand_access_timing_tb_top
